/* File: pscw_pkg.sv */
// pscw_pkg: constants and carrier types for the power-stage control bank.
// assumes a 25 MHz system clock and a 16-bit framed serial register link.
package pscw_pkg;

   // ==========================================================
   // register addresses and frame layout
   localparam logic [4:0] ADDR_SYS_CTRL = 5'h00;
   localparam logic [4:0] ADDR_HS_OUT = 5'h02;
   localparam logic [4:0] ADDR_HS_STAT = 5'h04;
   localparam logic [4:0] ADDR_WD_CTRL = 5'h0b;
   localparam logic [4:0] ADDR_SYS_STAT = 5'h0c;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] PARITY_EDGE = 5'h06;
   localparam int RW_BIT = 15;

   // ==========================================================
   // field positions
   localparam int PSE_BIT = 7;
   localparam int STOP_BIT = 6;
   localparam int SLEEP_BIT = 5;
   localparam int LS_THERMAL_SHUTDOWN_DISABLE_BIT = 4;
   localparam int HS_THERMAL_SHUTDOWN_DISABLE_BIT = 3;
   localparam int VIS_BIT = 2;
   localparam int SW_ON_BIT = 7;
   localparam int SW_OCF_BIT = 7;
   localparam int WD_ARM_BIT = 7;
   localparam int WD_KICK_BIT = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ==========================================================
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int WD_MIN_PERIOD_MS = 10;
   localparam int WD_MIN_PERIOD_CYCLES = CLK_HZ / 1000 * WD_MIN_PERIOD_MS;
   localparam int BUS_CL_LIMIT_CYCLES = 250;

   // ==========================================================
   // input synchroniser layout
   localparam int SYNC_W = 18;
   localparam int SCK_I = 17;
   localparam int SS_I = 16;
   localparam int MOSI_I = 15;
   localparam logic [17:0] SYNC_RESET = 18'h1_0000;

   typedef enum logic [1:0] {
      SLEW_20K = 2'b00,
      SLEW_8X = 2'b01,
      SLEW_10K = 2'b10,
      SLEW_4X = 2'b11
   } pscw_slew_t;

   typedef struct packed {
      logic [2:0] hs_oc;
      logic sw_oc;
      logic aux_oc;
      logic overtemp;
      logic low_v;
      logic high_v;
      logic [3:0] hb_fail;
      logic bus_cl;
      logic pulse;
      logic cpu_irq;
   } pscw_ana_t;

   typedef struct packed {
      logic [2:0] hs_drive;
      logic sw5v_enable;
      logic power_stage_enable;
      logic hb_high_off;
      logic hb_low_off;
      logic bus_tx_enable;
      pscw_slew_t bus_slew;
      logic stop_req;
      logic sleep_req;
      logic wd_system_reset;
   } pscw_drive_t;

   typedef struct packed {
      logic [17:0] s1;
      logic [17:0] s2;
      logic [17:0] s3;
      logic [17:0] filt;
      logic [15:0] rx;
      logic [4:0] fall_cnt;
      logic [4:0] rise_cnt;
      logic [7:0] stat_snap;
      logic [7:0] rdata;
      logic pse;
      logic ls_thermal_shutdown_disable;
      logic hs_thermal_shutdown_disable;
      logic voltage_shutdown_disable;
      pscw_slew_t slew;
      logic stop;
      logic sleep;
      logic [2:0] hs_force;
      logic [2:0] hs_pwm;
      logic sw_on;
      logic [2:0] hs_ocf;
      logic sw_ocf;
      logic wd_arm;
      logic [1:0] wd_per;
      logic [23:0] wd_cnt;
      logic [7:0] cl_cnt;
      logic miso;
      logic miso_oe;
      pscw_drive_t drv;
   } pscw_state_t;

endpackage

/* File: pscw_core.sv */
// pscw_core: control/status register bank, output gating and window watchdog
// of the power-stage die, reached over the internal 16-bit serial slave link.
// assumes spi pins and analog flags are asynchronous; spi clock well below clk/4.
`timescale 1ns/1ps
`default_nettype none

module pscw_core #(
   parameter int WD_BASE_CYCLES = pscw_pkg::WD_MIN_PERIOD_CYCLES, // 10 ms period
   parameter int BUS_CL_CYCLES = pscw_pkg::BUS_CL_LIMIT_CYCLES // current limit time
) (
   input wire logic clk, // system clock
   input wire logic rstn, // synchronous reset, low
   input wire logic ce, // clock enable
   input wire logic spi_sck, // serial clock from master
   input wire logic spi_ss_n, // slave select, low
   input wire logic spi_mosi, // serial data in
   input wire pscw_pkg::pscw_ana_t ana, // analog fault and control levels
   output logic spi_miso, // serial data out
   output logic spi_miso_oe, // miso driven while high
   output pscw_pkg::pscw_drive_t drive // gating and mode outputs
);

   // ==========================================================
   // state and combinational helpers
   pscw_pkg::pscw_state_t q;
   pscw_pkg::pscw_state_t next_q;
   pscw_pkg::pscw_ana_t af;
   logic [17:0] nf;
   logic sck_rise;
   logic sck_fall;
   logic ss_fall;
   logic ss_rise;
   logic commit;
   logic [4:0] wr_addr;
   logic [7:0] wdata;
   logic [7:0] sys_stat;
   logic [7:0] rd_mux;
   logic kick_commit;
   logic stop_ok;
   logic sleep_ok;
   logic sleep_entry;
   logic [23:0] per_cycles;
   logic [23:0] half_cycles;
   logic wd_fire;
   logic volt_shut;
   logic hs_shut;
   logic [2:0] hs_on;
   logic [15:0] frame_out;

   assign spi_miso = q.miso;
   assign spi_miso_oe = q.miso_oe;
   assign drive = q.drv;

   always_comb begin
      next_q = q;
      // ==========================================================
      // three-stage input filter: a bit moves once stages two and three agree
      next_q.s1 = {spi_sck, spi_ss_n, spi_mosi, ana};
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      nf = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));
      next_q.filt = nf;
      af = pscw_pkg::pscw_ana_t'(q.filt[14:0]);
      sck_rise = nf[pscw_pkg::SCK_I] & ~q.filt[pscw_pkg::SCK_I];
      sck_fall = ~nf[pscw_pkg::SCK_I] & q.filt[pscw_pkg::SCK_I];
      ss_fall = ~nf[pscw_pkg::SS_I] & q.filt[pscw_pkg::SS_I];
      ss_rise = nf[pscw_pkg::SS_I] & ~q.filt[pscw_pkg::SS_I];

      // ==========================================================
      // status byte and read multiplexer
      sys_stat = {af.bus_cl,
                  af.overtemp,
                  af.low_v | af.high_v,
                  af.aux_oc,
                  q.sw_ocf,
                  |q.hs_ocf,
                  |af.hb_fail,
                  1'b0};
      unique case (q.rx[4:0])
         pscw_pkg::ADDR_SYS_CTRL: begin
            rd_mux = {q.pse, 2'b00, q.ls_thermal_shutdown_disable, q.hs_thermal_shutdown_disable, q.voltage_shutdown_disable, q.slew};
         end
         pscw_pkg::ADDR_HS_OUT: begin
            rd_mux = {q.sw_on, 1'b0, q.hs_pwm, q.hs_force};
         end
         pscw_pkg::ADDR_HS_STAT: begin
            rd_mux = {q.sw_ocf, 4'h0, q.hs_ocf};
         end
         pscw_pkg::ADDR_WD_CTRL: begin
            rd_mux = {q.wd_arm, q.wd_per, 5'h00};
         end
         pscw_pkg::ADDR_SYS_STAT: begin
            rd_mux = sys_stat;
         end
         default: begin
            rd_mux = pscw_pkg::RESET_BYTE;
         end
      endcase

      // ==========================================================
      // serial frame: sample on falling sck, shift out on rising sck
      // shift-out word: snapped status first, then the addressed register
      frame_out = {q.stat_snap, q.rdata};
      if (ss_fall) begin
         next_q.fall_cnt = '0;
         next_q.rise_cnt = '0;
         next_q.stat_snap = sys_stat;
         next_q.rdata = pscw_pkg::RESET_BYTE;
         next_q.miso = 1'b0;
         next_q.miso_oe = 1'b1;
      end else if (nf[pscw_pkg::SS_I]) begin
         next_q.miso_oe = 1'b0;
         next_q.miso = 1'b0;
      end else begin
         if (sck_fall) begin
            next_q.rx = {q.rx[14:0], nf[pscw_pkg::MOSI_I]};
            if (q.fall_cnt == pscw_pkg::PARITY_EDGE) begin
               next_q.rdata = rd_mux;
            end
            if (q.fall_cnt != 5'h1f) begin
               next_q.fall_cnt = q.fall_cnt + 5'h01;
            end
         end
         if (sck_rise) begin
            if (q.rise_cnt < pscw_pkg::FRAME_BITS) begin
               next_q.miso = frame_out[~q.rise_cnt[3:0]];
            end
            if (q.rise_cnt != 5'h1f) begin
               next_q.rise_cnt = q.rise_cnt + 5'h01;
            end
         end
      end

      // a write counts only with exactly 16 samples, write flag low, even parity
      commit = ss_rise && q.fall_cnt == pscw_pkg::FRAME_BITS &&
               !q.rx[pscw_pkg::RW_BIT] && !(^q.rx[15:9]);
      wr_addr = q.rx[14:10];
      wdata = q.rx[7:0];
      kick_commit = commit && wr_addr == pscw_pkg::ADDR_WD_CTRL &&
                    wdata[pscw_pkg::WD_KICK_BIT];
      stop_ok = wdata[pscw_pkg::STOP_BIT] && !wdata[7] && wdata[5:2] == 4'h0;
      sleep_ok = wdata[pscw_pkg::SLEEP_BIT] && wdata[7:6] == 2'b00 &&
                 wdata[4:2] == 3'h0;
      sleep_entry = commit && wr_addr == pscw_pkg::ADDR_SYS_CTRL && sleep_ok;

      // ==========================================================
      // register writes
      if (commit && wr_addr == pscw_pkg::ADDR_SYS_CTRL) begin
         next_q.pse = wdata[pscw_pkg::PSE_BIT];
         next_q.ls_thermal_shutdown_disable = wdata[pscw_pkg::LS_THERMAL_SHUTDOWN_DISABLE_BIT];
         next_q.hs_thermal_shutdown_disable = wdata[pscw_pkg::HS_THERMAL_SHUTDOWN_DISABLE_BIT];
         next_q.voltage_shutdown_disable = wdata[pscw_pkg::VIS_BIT];
         next_q.slew = pscw_pkg::pscw_slew_t'(wdata[1:0]);
      end
      if (commit && wr_addr == pscw_pkg::ADDR_HS_OUT) begin
         next_q.sw_on = wdata[pscw_pkg::SW_ON_BIT];
         next_q.hs_pwm = wdata[5:3];
         next_q.hs_force = wdata[2:0];
      end
      // mode requests: a new request wins over an irq clear in the same cycle
      next_q.stop = (q.stop & ~af.cpu_irq) |
                    (commit && wr_addr == pscw_pkg::ADDR_SYS_CTRL && stop_ok);
      next_q.sleep = (q.sleep & ~af.cpu_irq) | sleep_entry;

      // fault flags: set wins over a write-one clear
      if (commit && wr_addr == pscw_pkg::ADDR_HS_STAT) begin
         next_q.hs_ocf = (q.hs_ocf & ~wdata[2:0]) | af.hs_oc;
         next_q.sw_ocf = (q.sw_ocf & ~wdata[pscw_pkg::SW_OCF_BIT]) | af.sw_oc;
      end else begin
         next_q.hs_ocf = q.hs_ocf | af.hs_oc;
         next_q.sw_ocf = q.sw_ocf | af.sw_oc;
      end

      // ==========================================================
      // window watchdog
      if (commit && wr_addr == pscw_pkg::ADDR_WD_CTRL) begin
         next_q.wd_per = wdata[6:5];
      end
      if (sleep_entry) begin
         next_q.wd_arm = 1'b0;
      end else if (commit && wr_addr == pscw_pkg::ADDR_WD_CTRL &&
                   wdata[pscw_pkg::WD_ARM_BIT]) begin
         next_q.wd_arm = 1'b1;
      end
      // code 00 is eight base periods, 11 is one base period
      per_cycles = 24'(WD_BASE_CYCLES) << ~q.wd_per;
      half_cycles = per_cycles >> 1;
      wd_fire = 1'b0;
      if (!q.wd_arm || sleep_entry) begin
         next_q.wd_cnt = '0;
      end else if (q.stop) begin
         // frozen while stopped, restarted from zero on wake-up
         next_q.wd_cnt = next_q.stop ? q.wd_cnt : '0;
      end else if (kick_commit) begin
         wd_fire = q.wd_cnt < half_cycles;
         next_q.wd_cnt = '0;
      end else if (q.wd_cnt >= per_cycles - 24'h00_0001) begin
         wd_fire = 1'b1;
         next_q.wd_cnt = '0;
      end else begin
         next_q.wd_cnt = q.wd_cnt + 24'h00_0001;
      end

      // ==========================================================
      // bus driver current-limit timer
      if (!af.bus_cl) begin
         next_q.cl_cnt = '0;
      end else if (32'(q.cl_cnt) < BUS_CL_CYCLES) begin
         next_q.cl_cnt = q.cl_cnt + 8'h01;
      end

      // ==========================================================
      // output gating
      volt_shut = (af.low_v | af.high_v) & ~q.voltage_shutdown_disable;
      hs_shut = ~q.pse | volt_shut | (af.overtemp & ~q.hs_thermal_shutdown_disable);
      for (int i = 0; i < 3; i++) begin
         // pulse mode follows the input or its force bit; plain force-on drops out on a fault
         hs_on[i] = q.hs_pwm[i] ? (q.hs_force[i] | af.pulse) :
                    (q.hs_force[i] & ~q.hs_ocf[i]);
      end
      next_q.drv.hs_drive = hs_shut ? 3'h0 : hs_on;
      next_q.drv.sw5v_enable = q.pse & q.sw_on;
      next_q.drv.power_stage_enable = q.pse;
      next_q.drv.hb_high_off = hs_shut;
      next_q.drv.hb_low_off = ~q.pse | volt_shut | (af.overtemp & ~q.ls_thermal_shutdown_disable);
      next_q.drv.bus_tx_enable = q.pse && 32'(q.cl_cnt) < BUS_CL_CYCLES;
      next_q.drv.bus_slew = q.slew;
      next_q.drv.stop_req = q.stop;
      next_q.drv.sleep_req = q.sleep;
      next_q.drv.wd_system_reset = wd_fire;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
         q.s1 <= pscw_pkg::SYNC_RESET;
         q.s2 <= pscw_pkg::SYNC_RESET;
         q.s3 <= pscw_pkg::SYNC_RESET;
         q.filt <= pscw_pkg::SYNC_RESET;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sw5v_gate_a: assert property (ce |=> drive.sw5v_enable == $past(q.pse & q.sw_on))
      else $error("switched 5v enable does not follow enable and supply-on");

   supply_ocf_set_a: assert property (ce && af.sw_oc |=> q.sw_ocf)
      else $error("supply overcurrent flag not held after fault");

   force_on_a: assert property (ce && q.hs_force[0] && !q.hs_pwm[0] && !q.hs_ocf[0]
      && !hs_shut |=> drive.hs_drive[0])
      else $error("forced high side not driven");

   pulse_follow_a: assert property (ce && q.hs_pwm[0] && !q.hs_force[0] && !hs_shut
      |=> drive.hs_drive[0] == $past(af.pulse))
      else $error("pulse-controlled high side does not follow pulse");

   ocf_hold_a: assert property (ce && q.hs_ocf[1] && !(commit &&
      wr_addr == pscw_pkg::ADDR_HS_STAT && wdata[1]) |=> q.hs_ocf[1])
      else $error("high side overcurrent flag lost without clear");

   stop_reject_a: assert property (ce && !q.stop && commit && wdata[pscw_pkg::STOP_BIT]
      && wdata[pscw_pkg::PSE_BIT] |=> !q.stop ##1 !drive.stop_req)
      else $error("stop request taken with other bits set");

   late_write_a: assert property (ce && !commit |=> $stable(q.hs_force) && $stable(q.pse))
      else $error("register changed without a committed frame");

   arm_sticky_a: assert property (ce && q.wd_arm && !sleep_entry |=> q.wd_arm)
      else $error("watchdog arm cleared by software");

   sleep_disarm_a: assert property (ce && sleep_entry |=> !q.wd_arm && q.wd_cnt == 24'h00_0000)
      else $error("sleep entry left watchdog armed");

   closed_kick_a: assert property (ce && q.wd_arm && !q.stop && kick_commit &&
      q.wd_cnt < half_cycles |=> drive.wd_system_reset)
      else $error("closed-window kick gave no system reset");

   stop_freeze_a: assert property (ce && q.stop && !af.cpu_irq && q.wd_arm && !sleep_entry
      |=> q.wd_cnt == $past(q.wd_cnt))
      else $error("watchdog counter moved in stop mode");

   sleep_reject_a: assert property (ce && !q.sleep && commit &&
      wr_addr == pscw_pkg::ADDR_SYS_CTRL && wdata[pscw_pkg::SLEEP_BIT] &&
      wdata[pscw_pkg::VIS_BIT] |=> !q.sleep)
      else $error("sleep request taken with other bits set");

   ocf_clear_a: assert property (ce && commit && wr_addr == pscw_pkg::ADDR_HS_STAT &&
      wdata[2] && !af.hs_oc[2] |=> !q.hs_ocf[2])
      else $error("high side overcurrent flag not cleared by write one");

   volt_gate_a: assert property (ce && (af.low_v || af.high_v) && !q.voltage_shutdown_disable
      |=> drive.hs_drive == 3'h0)
      else $error("high sides still driven during a voltage fault");

   bus_cl_off_a: assert property (ce && 32'(q.cl_cnt) >= BUS_CL_CYCLES
      |=> !drive.bus_tx_enable)
      else $error("bus driver left on after current limit time");

   period_end_a: assert property (ce && q.wd_arm && !q.stop && !sleep_entry &&
      !kick_commit && q.wd_cnt == per_cycles - 24'h00_0001 |=> drive.wd_system_reset)
      else $error("watchdog period ended without a system reset");

   open_kick_a: assert property (ce && q.wd_arm && !q.stop && kick_commit &&
      q.wd_cnt >= half_cycles |=> !drive.wd_system_reset && q.wd_cnt == 24'h00_0000)
      else $error("open-window kick did not restart the watchdog quietly");

   slew_follow_a: assert property (ce |=> drive.bus_slew == $past(q.slew))
      else $error("bus slew output does not follow its select");

endmodule

`default_nettype wire

/* File: pscw_spi_master.sv */
// pscw_spi_master: behavioural serial master in place of the processor.
// assumes the bench clock; sck half period of 10 clk, sck and mosi low and ss_n high when idle.
`timescale 1ns/1ps
`default_nettype none
module pscw_spi_master (
   input wire logic clk, // system clock
   output logic sck, // serial clock
   output logic ss_n, // slave select, low
   output logic mosi, // serial data out
   input wire logic miso // serial data in
);
   // ======
   // frame engine
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // data changes with sck rise and holds over the fall; nclk below 16 is a short frame
   task automatic xfer(input logic [15:0] w, input int nclk, output logic [15:0] r);
      r = 16'h0000;
      tick(1);
      ss_n = 1'b0;
      tick(10);
      for (int i = 0; i < nclk; i++) begin
         sck = 1'b1;
         mosi = w[15-i];
         tick(10);
         r = {r[14:0], miso};
         sck = 1'b0;
         tick(10);
      end
      ss_n = 1'b1;
      mosi = 1'b0;
      tick(12);
   endtask
endmodule
`default_nettype wire

/* File: power_stage_control_status_wdog_bench.sv */
// power_stage_control_status_wdog_bench: self-checking bench for pscw_core.
// assumes pscw_pkg and pscw_spi_master; watchdog base shortened to 128 clk.
`timescale 1ns/1ps
`default_nettype none
module power_stage_control_status_wdog_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   pscw_pkg::pscw_ana_t ana = '0;
   wire logic sck, ss_n, mosi, miso, miso_oe;
   pscw_pkg::pscw_drive_t drive;
   logic [15:0] r;
   int n_errors = 0;
   int total_checks = 0;
   int n_pulse = 0;
   int n;
   int p;

   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (drive.wd_system_reset === 1'b1) begin
         n_pulse <= n_pulse + 1;
      end
   end

   pscw_core #(.WD_BASE_CYCLES(128), .BUS_CL_CYCLES(8)) u_dut (
      .clk(clk), .rstn(rstn), .ce(1'b1), .spi_sck(sck), .spi_ss_n(ss_n),
      .spi_mosi(mosi), .ana(ana), .spi_miso(miso), .spi_miso_oe(miso_oe), .drive(drive)
   );
   pscw_spi_master u_mst (.clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));

   // ======
   // helpers
   task automatic tk(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   function automatic logic [15:0] fr(input logic rw, input logic [4:0] a, input logic [7:0] d);
      return {rw, a, ^{rw, a}, 1'b0, d}; // even parity over command
   endfunction
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_mst.xfer(fr(1'b0, a, d), 16, r);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
      u_mst.xfer(fr(1'b1, a, 8'h00), 16, r);
      chk(nm, e, r[7:0]);
   endtask
   task automatic gap(output int c);
      int q;
      q = n_pulse;
      c = 0;
      while (n_pulse == q && c < 3000) begin
         tk(1);
         c++;
      end
   endtask
   task automatic irq;
      ana.cpu_irq = 1'b1;
      tk(8);
      ana.cpu_irq = 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ======
   // scenarios
   task automatic t_reset;
      // power stage off holds both bridge sides off, everything else low
      chk("drive_hi", 8'h06, 8'(drive[12:5]));
      chk("drive_lo", 8'h00, 8'(drive[4:0]));
      chk("oe", 8'h00, 8'(miso_oe));
      rd(5'h00, 8'h00, "sys_ctrl");
      rd(5'h02, 8'h00, "hs_out");
      rd(5'h04, 8'h00, "hs_stat");
      rd(5'h0b, 8'h00, "wd_ctrl");
      rd(5'h05, 8'h00, "unmapped");
      rd(5'h0c, 8'h00, "sys_stat");
      chk("status", 8'h00, r[15:8]);
      $display("reset test done");
   endtask
   task automatic t_hs;
      wr(5'h00, 8'h80);
      wr(5'h02, 8'h8a);
      chk("hs_drive", 8'h02, 8'(drive.hs_drive));
      chk("sw5v", 8'h01, 8'(drive.sw5v_enable));
      ana.pulse = 1'b1;
      tk(8);
      chk("hs_drive", 8'h03, 8'(drive.hs_drive));
      ana.low_v = 1'b1;
      tk(8);
      chk("hs_drive", 8'h00, 8'(drive.hs_drive));
      chk("sw5v", 8'h01, 8'(drive.sw5v_enable));
      ana.low_v = 1'b0;
      ana.pulse = 1'b0;
      u_mst.xfer(fr(1'b0, 5'h02, 8'h00) ^ 16'h0200, 16, r);
      u_mst.xfer(fr(1'b0, 5'h02, 8'h00), 15, r);
      rd(5'h02, 8'h8a, "hs_out");
      wr(5'h00, 8'h00);
      chk("sw5v", 8'h00, 8'(drive.sw5v_enable));
      chk("hs_drive", 8'h00, 8'(drive.hs_drive));
      $display("high-side test done");
   endtask
   task automatic t_ocf;
      wr(5'h00, 8'h80);
      wr(5'h02, 8'h84);
      chk("hs_drive", 8'h04, 8'(drive.hs_drive));
      ana.hs_oc = 3'b100;
      ana.sw_oc = 1'b1;
      tk(8);
      ana.hs_oc = 3'b000;
      ana.sw_oc = 1'b0;
      tk(8);
      chk("hs_drive", 8'h00, 8'(drive.hs_drive));
      chk("sw5v", 8'h01, 8'(drive.sw5v_enable));
      rd(5'h04, 8'h84, "hs_stat");
      rd(5'h0c, 8'h0c, "sys_stat");
      wr(5'h04, 8'h00);
      rd(5'h04, 8'h84, "hs_stat");
      wr(5'h04, 8'h04);
      rd(5'h04, 8'h80, "hs_stat");
      chk("hs_drive", 8'h04, 8'(drive.hs_drive));
      wr(5'h04, 8'h80);
      rd(5'h04, 8'h00, "hs_stat");
      wr(5'h00, 8'h00);
      $display("overcurrent test done");
   endtask
   task automatic t_prot;
      wr(5'h00, 8'h80);
      chk("bus_tx", 8'h01, 8'(drive.bus_tx_enable));
      ana.bus_cl = 1'b1;
      tk(20);
      chk("bus_tx", 8'h00, 8'(drive.bus_tx_enable));
      ana.overtemp = 1'b1;
      ana.aux_oc = 1'b1;
      ana.low_v = 1'b1;
      ana.hb_fail = 4'b0100;
      tk(8);
      rd(5'h0c, 8'hf2, "sys_stat");
      chk("status", 8'hf2, r[15:8]);
      chk("low_off", 8'h01, 8'(drive.hb_low_off));
      chk("high_off", 8'h01, 8'(drive.hb_high_off));
      wr(5'h00, 8'h9c);
      chk("low_off", 8'h00, 8'(drive.hb_low_off));
      chk("high_off", 8'h00, 8'(drive.hb_high_off));
      wr(5'h02, 8'h01);
      chk("hs_drive", 8'h01, 8'(drive.hs_drive));
      wr(5'h00, 8'h98);
      chk("hs_drive", 8'h00, 8'(drive.hs_drive));
      ana = '0;
      ana.high_v = 1'b1;
      tk(8);
      rd(5'h0c, 8'h20, "sys_stat");
      ana.high_v = 1'b0;
      for (int s = 0; s < 4; s++) begin
         wr(5'h00, 8'(s));
         chk("slew", 8'(s), 8'(drive.bus_slew));
      end
      wr(5'h00, 8'h00);
      $display("protection test done");
   endtask
   task automatic t_wd;
      wr(5'h0b, 8'he0);
      wr(5'h0b, 8'h60);
      rd(5'h0b, 8'he0, "wd_ctrl");
      for (int k = 0; k < 4; k++) begin
         wr(5'h0b, {1'b1, 2'(k), 5'h00});
         gap(n);
         gap(n);
         rng("period", (128 << (3 - k)) - 1, (128 << (3 - k)) + 1, n);
      end
      wr(5'h0b, 8'h80);
      gap(n);
      p = n_pulse;
      wr(5'h0b, 8'h81);
      chk("pulses", 8'(p + 1), 8'(n_pulse));
      p = n_pulse;
      tk(300);
      wr(5'h0b, 8'h81);
      tk(800);
      chk("pulses", 8'(p), 8'(n_pulse));
      gap(n);
      rng("open", 200, 235, n);
      $display("watchdog test done");
   endtask
   task automatic t_mode;
      wr(5'h00, 8'hc0);
      chk("stop", 8'h00, 8'(drive.stop_req));
      wr(5'h00, 8'h40);
      chk("stop", 8'h01, 8'(drive.stop_req));
      p = n_pulse;
      tk(1500);
      chk("pulses", 8'(p), 8'(n_pulse));
      irq();
      chk("stop", 8'h00, 8'(drive.stop_req));
      gap(n);
      rng("resume", 1010, 1030, n);
      wr(5'h00, 8'h24);
      chk("sleep", 8'h00, 8'(drive.sleep_req));
      wr(5'h00, 8'h20);
      chk("sleep", 8'h01, 8'(drive.sleep_req));
      p = n_pulse;
      rd(5'h0b, 8'h00, "wd_ctrl");
      tk(1200);
      chk("pulses", 8'(p), 8'(n_pulse));
      irq();
      chk("sleep", 8'h00, 8'(drive.sleep_req));
      wr(5'h0b, 8'h80);
      rd(5'h0b, 8'h80, "wd_ctrl");
      $display("mode test done");
   endtask

   // ======
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      tk(8);
      t_reset();
      t_hs();
      t_ocf();
      t_prot();
      t_wd();
      t_mode();
      conclude();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
